/* rtl/dgc_cfg.svh */
// dgc_cfg.svh: offsets, fields, reset values and counts of the dma global control block
// assumes: included by bare name from the dgc package and design modules
`ifndef DGC_CFG_SVH
`define DGC_CFG_SVH

// ****************************************************************
// register map (printed word offsets are not multiples of four)
// ****************************************************************
`define DGC_IDX_RESET_CTRL 3'h0
`define DGC_IDX_HALT_BEH 3'h1
`define DGC_IDX_IDENT 3'h2
`define DGC_IDX_SOFT_RESET 3'h3
`define DGC_IDX_STATUS 3'h4
`define DGC_ADDR_W 5

// ****************************************************************
// fields
// ****************************************************************
`define DGC_BIT_MODULE_RESET 0
`define DGC_BIT_ARB_RESTART 1
`define DGC_BIT_RUN_FREE 15
`define DGC_NUM_CH 6

// ****************************************************************
// reset values and identification (arbitrary neutral codes)
// ****************************************************************
`define DGC_RST_HALT_BEH 16'h0000
`define DGC_CLASS_CODE 8'h5A
`define DGC_STEP_CODE 8'hA5
`define DGC_MODRST_DELAY 2'h1

`endif

/* rtl/dgc_pkg.sv */
// dgc_pkg.sv: types shared by the dma global control block
// assumes: dgc_cfg.svh on the include path
`include "dgc_cfg.svh"
package dgc_pkg;
  typedef enum logic [1:0] {
    ARB_IDLE,
    ARB_WAIT_HIGH,
    ARB_WAIT_LOW,
    ARB_APPLY
  } dgc_arb_state_t;
  typedef logic [`DGC_NUM_CH-1:0] dgc_ch_mask_t;
endpackage

/* rtl/dgc_restart_seq.sv */
// dgc_restart_seq.sv: holds an arbiter restart request until bursts drain
// assumes: burst status from the transfer engine on mclk_i
`timescale 1ns/1ps
`include "dgc_cfg.svh"
module dgc_restart_seq (
  input wire logic mclk_i, // system clock
  input wire logic rst_i, // sync reset, high
  input wire logic ce_i, // clock enable
  input wire logic req_i, // restart request pulse
  input wire logic high_burst_i, // first channel elevated burst busy
  input wire logic low_burst_i, // other channel burst busy or preempted
  output logic restart_o // one-cycle arbiter reinit pulse
);
  import dgc_pkg::*;

  dgc_arb_state_t state_ff;
  dgc_arb_state_t nxt_state;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ARB_IDLE: begin
        if (req_i) begin
          nxt_state = ARB_WAIT_HIGH;
        end
      end
      // elevated burst finishes first, then the interrupted one
      ARB_WAIT_HIGH: begin
        if (!high_burst_i) begin
          nxt_state = ARB_WAIT_LOW;
        end
      end
      ARB_WAIT_LOW: begin
        if (!low_burst_i && !high_burst_i) begin
          nxt_state = ARB_APPLY;
        end
      end
      ARB_APPLY: nxt_state = ARB_IDLE;
      default: nxt_state = ARB_IDLE;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      state_ff <= ARB_IDLE;
    end else if (ce_i) begin
      state_ff <= nxt_state;
    end
  end

  assign restart_o = (state_ff == ARB_APPLY) && ce_i;
endmodule // dgc_restart_seq

/* rtl/dgc_top.sv */
// dgc_top.sv: dma global control registers behind an avalon-mm slave
// assumes: transfer engine on mclk_i; halt and ready pins are asynchronous
// assumes: software idles one cycle after writing the module reset bit
//
// Our own choices: the address map and the Avalon-MM register port.
`timescale 1ns/1ps
`include "dgc_cfg.svh"
module dgc_top (
  input wire logic mclk_i, // 125 MHz system clock
  input wire logic rst_i, // sync reset, high
  input wire logic ce_i, // clock enable, freezes all state when low
  input wire logic [`DGC_ADDR_W-1:0] avs_address_i, // byte address
  input wire logic avs_read_i, // read request
  input wire logic avs_write_i, // write request
  input wire logic [31:0] avs_writedata_i, // write data
  input wire logic [3:0] avs_byteenable_i, // byte enables
  output logic [31:0] avs_readdata_o, // read data
  output logic avs_waitrequest_o, // stall
  output logic [1:0] avs_response_o, // 00 okay, 10 slave error
  input wire logic write_unlock_i, // protected write unlock level
  input wire logic emu_halt_i, // emulation halt request, async pin
  input wire logic access_busy_i, // engine read-write access in progress
  input wire logic ext_port_busy_i, // port transaction pending
  input wire logic external_wait_release_i, // external ready pin, async
  input wire logic first_channel_high_i, // first channel elevated priority
  input wire logic high_burst_i, // first channel burst under way
  input wire logic low_burst_i, // other burst under way or preempted
  output logic arbiter_restart_o, // one-cycle arbiter reinit pulse
  output logic [2:0] arb_start_ch_o, // channel where service resumes
  output logic whole_module_reset_o, // one-cycle reset to whole engine
  output logic access_abort_o, // abort current access incl stalled
  output logic ext_port_hold_o, // port finishing aborted transaction
  output logic dma_freeze_o, // freeze dma state
  output logic [`DGC_NUM_CH-1:0] ch_soft_reset_o // per channel soft reset pulse
);
  import dgc_pkg::*;

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [2:0] word_idx(input logic [`DGC_ADDR_W-1:0] a);
    word_idx = a[`DGC_ADDR_W-1:2];
  endfunction

  function automatic logic lane_hit(input logic [3:0] be, input int bitpos);
    lane_hit = be[bitpos/8];
  endfunction

  function automatic logic set_hit(input logic [3:0] be, input logic [31:0] d, input int bitpos);
    set_hit = lane_hit(be, bitpos) && d[bitpos];
  endfunction

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic halt_s1_ff, halt_s2_ff, nxt_halt_s1, nxt_halt_s2;
  logic rdy_s1_ff, rdy_s2_ff, nxt_rdy_s1, nxt_rdy_s2;

  // emulation halt request
  always_comb begin
    nxt_halt_s1 = emu_halt_i;
    nxt_halt_s2 = halt_s1_ff;
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      halt_s1_ff <= 1'b0;
      halt_s2_ff <= 1'b0;
    end else if (ce_i) begin
      halt_s1_ff <= nxt_halt_s1;
      halt_s2_ff <= nxt_halt_s2;
    end
  end

  // external ready, high when released
  always_comb begin
    nxt_rdy_s1 = external_wait_release_i;
    nxt_rdy_s2 = rdy_s1_ff;
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      rdy_s1_ff <= 1'b0;
      rdy_s2_ff <= 1'b0;
    end else if (ce_i) begin
      rdy_s1_ff <= nxt_rdy_s1;
      rdy_s2_ff <= nxt_rdy_s2;
    end
  end

  // ****************************************************************
  // bus slave: one wait cycle, answer on second cycle
  // ****************************************************************
  logic ack_ff, nxt_ack;
  logic [31:0] rdata_ff, nxt_rdata;
  logic [1:0] resp_ff, nxt_resp;
  logic req;
  logic wr_take;
  logic [2:0] idx;
  logic mapped;

  assign req = avs_read_i || avs_write_i;
  assign idx = word_idx(avs_address_i);
  assign mapped = (idx <= `DGC_IDX_STATUS);
  assign wr_take = avs_write_i && ack_ff && write_unlock_i && mapped;
  // no answer while frozen, or the master would see a write that never landed
  assign avs_waitrequest_o = req && !(ack_ff && ce_i);
  assign avs_readdata_o = rdata_ff;
  assign avs_response_o = resp_ff;

  // ****************************************************************
  // registers
  // ****************************************************************
  logic run_free_ff, nxt_run_free;
  logic modrst_pend_ff, nxt_modrst_pend;
  logic modrst_ff, nxt_modrst;
  logic restart_req_ff, nxt_restart_req;
  logic hold_ff, nxt_hold;
  logic freeze_ff, nxt_freeze;
  dgc_ch_mask_t soft_ff, nxt_soft;
  logic restart_pulse;
  logic wr_ctrl;
  localparam logic [15:0] RST_HALT_BEH = `DGC_RST_HALT_BEH;
  localparam logic RST_RUN_FREE = RST_HALT_BEH[`DGC_BIT_RUN_FREE];

  assign wr_ctrl = wr_take && (idx == `DGC_IDX_RESET_CTRL);

  always_comb begin
    nxt_ack = req && !ack_ff;
    nxt_rdata = rdata_ff;
    nxt_resp = resp_ff;
    if (req && !ack_ff) begin
      nxt_rdata = 32'h0000_0000;
      nxt_resp = mapped ? 2'h0 : 2'h2;
      case (idx)
        `DGC_IDX_RESET_CTRL: nxt_rdata = 32'h0000_0000;
        `DGC_IDX_HALT_BEH: nxt_rdata[`DGC_BIT_RUN_FREE] = run_free_ff;
        `DGC_IDX_IDENT: nxt_rdata[15:0] = {`DGC_CLASS_CODE, `DGC_STEP_CODE};
        `DGC_IDX_STATUS: nxt_rdata[3:0] = {hold_ff, freeze_ff, modrst_pend_ff, restart_req_ff};
        default: nxt_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      resp_ff <= 2'h0;
    end else if (ce_i) begin
      ack_ff <= nxt_ack;
      rdata_ff <= nxt_rdata;
      resp_ff <= nxt_resp;
    end
  end

  // ****************************************************************
  // halt behaviour and channel soft resets
  // ****************************************************************
  always_comb begin
    nxt_run_free = run_free_ff;
    nxt_soft = '0;
    if (wr_take && (idx == `DGC_IDX_HALT_BEH)) begin
      if (lane_hit(avs_byteenable_i, `DGC_BIT_RUN_FREE)) begin
        nxt_run_free = avs_writedata_i[`DGC_BIT_RUN_FREE];
      end
    end
    if (wr_take && (idx == `DGC_IDX_SOFT_RESET)) begin
      if (avs_byteenable_i[0]) begin
        nxt_soft = avs_writedata_i[`DGC_NUM_CH-1:0];
      end
    end
    // module reset puts settings back to their reset values
    if (modrst_ff) begin
      nxt_run_free = RST_RUN_FREE;
      nxt_soft = '0;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      run_free_ff <= RST_RUN_FREE;
      soft_ff <= '0;
    end else if (ce_i) begin
      run_free_ff <= nxt_run_free;
      soft_ff <= nxt_soft;
    end
  end

  // ****************************************************************
  // self-clearing reset control
  // ****************************************************************
  always_comb begin
    nxt_restart_req = 1'b0;
    nxt_modrst_pend = 1'b0;
    // only ones act; zeros and reserved bits are dropped
    if (wr_ctrl) begin
      nxt_restart_req = set_hit(avs_byteenable_i, avs_writedata_i,
        `DGC_BIT_ARB_RESTART);
      nxt_modrst_pend = set_hit(avs_byteenable_i, avs_writedata_i,
        `DGC_BIT_MODULE_RESET);
    end
    // a restart still queued is dropped by the module reset
    if (modrst_ff) begin
      nxt_restart_req = 1'b0;
    end
    // pending write becomes the reset one cycle later
    nxt_modrst = modrst_pend_ff;
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      restart_req_ff <= 1'b0;
      modrst_pend_ff <= 1'b0;
      modrst_ff <= 1'b0;
    end else if (ce_i) begin
      restart_req_ff <= nxt_restart_req;
      modrst_pend_ff <= nxt_modrst_pend;
      modrst_ff <= nxt_modrst;
    end
  end

  // ****************************************************************
  // external port hold after an abort
  // ****************************************************************
  // aborted stalled port transfer holds until ready is released
  always_comb begin
    nxt_hold = hold_ff;
    if (modrst_pend_ff && ext_port_busy_i && !rdy_s2_ff) begin
      nxt_hold = 1'b1;
    end else if (rdy_s2_ff) begin
      nxt_hold = 1'b0;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      hold_ff <= 1'b0;
    end else if (ce_i) begin
      hold_ff <= nxt_hold;
    end
  end

  // ****************************************************************
  // emulation freeze
  // ****************************************************************
  // freeze only between accesses when not run free
  always_comb begin
    nxt_freeze = freeze_ff;
    if (!halt_s2_ff || run_free_ff || modrst_ff) begin
      nxt_freeze = 1'b0;
    end else if (!access_busy_i) begin
      nxt_freeze = 1'b1;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      freeze_ff <= 1'b0;
    end else if (ce_i) begin
      freeze_ff <= nxt_freeze;
    end
  end

  // ****************************************************************
  // arbiter restart sequencing
  // ****************************************************************
  dgc_restart_seq u_restart (
    .mclk_i(mclk_i),
    .rst_i(rst_i || modrst_ff),
    .ce_i(ce_i),
    .req_i(restart_req_ff),
    // a first channel burst is drained whether elevated or not
    .high_burst_i(high_burst_i),
    .low_burst_i(low_burst_i),
    .restart_o(restart_pulse)
  );

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign arbiter_restart_o = restart_pulse || modrst_ff;
  assign arb_start_ch_o = first_channel_high_i ? 3'h1 : 3'h0;
  assign whole_module_reset_o = modrst_ff;
  assign access_abort_o = modrst_ff;
  assign ext_port_hold_o = hold_ff;
  assign dma_freeze_o = freeze_ff && !run_free_ff;
  assign ch_soft_reset_o = soft_ff;
endmodule // dgc_top

/* sim/dgc_top_chk.sv */
// dgc_top_chk.sv: port assertions for dgc_top
// assumes: bound to dgc_top, one clock domain
`timescale 1ns/1ps
`include "dgc_cfg.svh"
module dgc_top_chk (
  input wire logic mclk_i, // clock
  input wire logic rst_i, // reset
  input wire logic [`DGC_ADDR_W-1:0] avs_address_i, // address
  input wire logic avs_read_i, // read
  input wire logic avs_write_i, // write
  input wire logic [31:0] avs_writedata_i, // wdata
  input wire logic [31:0] avs_readdata_o, // rdata
  input wire logic avs_waitrequest_o, // stall
  input wire logic write_unlock_i, // unlock
  input wire logic access_busy_i, // busy
  input wire logic first_channel_high_i, // elevated
  input wire logic high_burst_i, // burst
  input wire logic low_burst_i, // burst
  input wire logic arbiter_restart_o, // restart
  input wire logic [2:0] arb_start_ch_o, // start
  input wire logic whole_module_reset_o, // reset out
  input wire logic access_abort_o, // abort
  input wire logic dma_freeze_o // freeze
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  wire logic ok = !avs_waitrequest_o;
  wire logic [2:0] idx = avs_address_i[4:2];
  wire logic mrw = avs_write_i && ok && idx == `DGC_IDX_RESET_CTRL && avs_writedata_i[0];
  property p_mr_delay; mrw && write_unlock_i |=> !whole_module_reset_o ##1 whole_module_reset_o;
  endproperty
  property p_locked; mrw && !write_unlock_i |=> ##1 !whole_module_reset_o; endproperty
  property p_mr_all;
    whole_module_reset_o |-> access_abort_o && arbiter_restart_o ##1 !whole_module_reset_o;
  endproperty
  property p_start; arb_start_ch_o == (first_channel_high_i ? 3'h1 : 3'h0); endproperty
  property p_drain;
    arbiter_restart_o && !whole_module_reset_o |-> !$past(low_burst_i) && !$past(high_burst_i);
  endproperty
  property p_rd0; avs_read_i && ok && idx == 3'h0 |-> avs_readdata_o == 32'h0; endproperty
  property p_ident; avs_read_i && ok && idx == 3'h2
    |-> avs_readdata_o == {16'h0000, `DGC_CLASS_CODE, `DGC_STEP_CODE}; endproperty
  property p_freeze; $rose(dma_freeze_o) |-> !$past(access_busy_i); endproperty
  a_mr_delay: assert property (p_mr_delay) else $error("module reset timing");
  a_locked: assert property (p_locked) else $error("locked write acted");
  a_mr_all: assert property (p_mr_all) else $error("module reset incomplete");
  a_start: assert property (p_start) else $error("start channel wrong");
  a_drain: assert property (p_drain) else $error("restart during burst");
  a_rd0: assert property (p_rd0) else $error("control read not zero");
  a_ident: assert property (p_ident) else $error("identification wrong");
  a_freeze: assert property (p_freeze) else $error("freeze during access");
  c_mr: cover property (whole_module_reset_o);
  c_rs: cover property (arbiter_restart_o && !whole_module_reset_o);
  c_fz: cover property (dma_freeze_o);
endmodule // dgc_top_chk
bind dgc_top dgc_top_chk u_chk (.mclk_i, .rst_i, .avs_address_i, .avs_read_i, .avs_write_i,
  .avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o, .write_unlock_i, .access_busy_i,
  .first_channel_high_i, .high_burst_i, .low_burst_i, .arbiter_restart_o, .arb_start_ch_o,
  .whole_module_reset_o, .access_abort_o, .dma_freeze_o);

/* sim/dgc_top_tb_top.sv */
// dgc_top_tb_top.sv: self-checking bench for dgc_top
// assumes: dgc_top_chk bound; ce_i driven by the bench
`timescale 1ns/1ps
`include "dgc_cfg.svh"
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin failures++; \
  $display("unexpected %s exp %0h got %0h", nm, e, g); end end
module dgc_top_tb_top;
  logic mclk_i = 0, rst_i = 1, rd = 0, wr = 0, unl = 0, halt = 0, busy = 0, pb = 0, rel = 1;
  logic fch = 0, hb = 0, lb = 0, ce = 1, wq, ar, mr, ab, ph, fz;
  logic [4:0] adr = 0;
  logic [31:0] wd = 0, rdat, rdo, rv;
  logic [1:0] rsp, rso;
  logic [2:0] sc;
  logic [5:0] sr, sr_seen = 0;
  int failures = 0, n_checks = 0, cyc = 0, n_mr = 0, n_ar = 0, n_ab = 0, hb_m = 0;
  dgc_top dut (.mclk_i(mclk_i), .rst_i(rst_i), .ce_i(ce), .avs_address_i(adr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(4'hF),
    .avs_readdata_o(rdo), .avs_waitrequest_o(wq), .avs_response_o(rso),
    .write_unlock_i(unl), .emu_halt_i(halt), .access_busy_i(busy), .ext_port_busy_i(pb),
    .external_wait_release_i(rel), .first_channel_high_i(fch), .high_burst_i(hb),
    .low_burst_i(lb), .arbiter_restart_o(ar), .arb_start_ch_o(sc),
    .whole_module_reset_o(mr), .access_abort_o(ab), .ext_port_hold_o(ph),
    .dma_freeze_o(fz), .ch_soft_reset_o(sr));
  always #4 mclk_i = ~mclk_i;
  always @(posedge mclk_i) begin
    cyc++;
    // outputs are unknown until the first reset edge has landed
    if (!rst_i) begin
      n_mr += mr;
      n_ar += ar;
      n_ab += ab;
      sr_seen |= sr;
    end
    if (cyc == 3000) begin
      failures++;
      summarize();
    end
  end
  task automatic bus(input bit w, input [2:0] i, input [31:0] d);
    @(posedge mclk_i);
    adr <= {i, 2'b00};
    wr <= w;
    rd <= !w;
    wd <= d;
    do @(posedge mclk_i); while (wq !== 1'b0);
    rdat = rdo;
    rsp = rso;
    wr <= 0;
    rd <= 0;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge mclk_i);
  endtask
  task summarize;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // ****
  // register access
  // ****
  initial begin
    void'($urandom(18363));
    repeat (6) @(posedge mclk_i);
    rst_i <= 0;
    bus(0, 2, 0);
    `CHK("ident", {16'h0000, `DGC_CLASS_CODE, `DGC_STEP_CODE}, rdat)
    bus(0, 0, 0); `CHK("ctrl", 32'h0, rdat)
    bus(0, 5, 0); `CHK("resp", 2'b10, rsp)
    for (int k = 0; k < 2; k++) begin
      unl <= k[0];
      bus(1, 1, $urandom | 32'h8000);
      if (k == 1) hb_m = 32'h8000;
      bus(0, 1, 0); `CHK("halt reg", hb_m, rdat)
    end
    halt <= 1;
    idle(8); `CHK("run free", 1'b0, fz)
    busy <= 1;
    bus(1, 1, 0);
    idle(8); `CHK("frz busy", 1'b0, fz)
    busy <= 0;
    idle(8); `CHK("frz", 1'b1, fz)
    halt <= 0;
    idle(8);
    ce <= 0;
    halt <= 1;
    idle(8);
    `CHK("ce frozen", 1'b0, fz)
    ce <= 1;
    idle(8);
    `CHK("ce thawed", 1'b1, fz)
    halt <= 0;
    // ****
    // arbiter restart
    // ****
    fch <= 1;
    hb <= 1;
    lb <= 1;
    bus(1, 0, 2);
    idle(8); `CHK("restart", 0, n_ar)
    hb <= 0;
    idle(8); `CHK("restart", 0, n_ar)
    lb <= 0;
    idle(8); `CHK("restart", 1, n_ar)
    `CHK("start", 3'h1, sc)
    fch <= 0;
    bus(1, 0, 0);
    idle(8); `CHK("zero wr", 1, n_ar + n_mr)
    `CHK("start", 3'h0, sc)
    unl <= 0;
    bus(1, 0, 1);
    idle(4); `CHK("locked", 0, n_mr)
    unl <= 1;
    rv = $urandom | 32'h1;
    bus(1, 3, rv);
    idle(4); `CHK("soft", rv[5:0], sr_seen)
    // ****
    // module reset with stalled port
    // ****
    bus(1, 1, 32'h8000);
    pb <= 1;
    rel <= 0;
    bus(1, 0, 1);
    idle(6);
    `CHK("mod rst", 1, n_mr)
    `CHK("abort", 1, n_ab)
    `CHK("hold", 1'b1, ph)
    rel <= 1;
    pb <= 0;
    idle(6); `CHK("hold", 1'b0, ph)
    bus(0, 1, 0); `CHK("halt rst", 32'h0, rdat)
    summarize();
  end
endmodule // dgc_top_tb_top
